// >>> logic/ssq_pkg.sv
// package for the scan and motion command sequencer: register map, commands, timing
// assumes a byte-wide config register port (address write, then data access) from the usb core
package ssq_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [6:0] SSQ_REG_IMAGE = 7'h00;
  localparam logic [6:0] SSQ_REG_FILL = 7'h01;
  localparam logic [6:0] SSQ_REG_CMD = 7'h07;
  localparam logic [6:0] SSQ_REG_MCLK = 7'h08;
  localparam logic [6:0] SSQ_REG_FFHI = 7'h48;
  localparam logic [6:0] SSQ_REG_FFLO = 7'h49;
  localparam logic [6:0] SSQ_REG_SKHI = 7'h4a;
  localparam logic [6:0] SSQ_REG_SKLO = 7'h4b;
  // ----------------------------------------
  // command codes and fields
  // ----------------------------------------
  localparam logic [2:0] SSQ_CMD_IDLE = 3'h0;
  localparam logic [2:0] SSQ_CMD_FWD = 3'h1;
  localparam logic [2:0] SSQ_CMD_REV = 3'h2;
  localparam logic [2:0] SSQ_CMD_SCAN = 3'h3;
  localparam logic [2:0] SSQ_CMD_PFWD = 3'h5;
  localparam logic [2:0] SSQ_CMD_PREV = 3'h6;
  localparam int SSQ_CMD_LO = 0;
  localparam int SSQ_CMD_HI = 2;
  localparam logic [7:0] SSQ_RST_BYTE = 8'h00;
  localparam logic [5:0] SSQ_MCLK_MASK = 6'h3f;
  // ----------------------------------------
  // fifo and timing
  // ----------------------------------------
  localparam int SSQ_FIFO_W = 8;
  localparam int SSQ_FIFO_D = 16;
  localparam int SSQ_FIFO_AW = 4;
  localparam int SSQ_HOLD_MS = 100;
  localparam int SSQ_CLK_MHZ = 100;
  localparam int SSQ_HOLD_CYC = SSQ_HOLD_MS * 1000 * SSQ_CLK_MHZ;
  typedef enum logic [4:0] {
    SSQ_ST_IDLE = 5'b00001,
    SSQ_ST_SKIP = 5'b00010,
    SSQ_ST_SCAN = 5'b00100,
    SSQ_ST_FEED = 5'b01000,
    SSQ_ST_TAIL = 5'b10000
  } ssq_state_t;
endpackage

// >>> logic/ssq_fifo.sv
// line buffer fifo, parameterised width and depth
// assumes one clock, synchronous flush
`timescale 1ns/100ps
`default_nettype none
module ssq_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clock, // clock
  input wire logic rst_n, // async reset
  input wire logic flush, // clear contents
  input wire logic in_valid, // write request
  output logic in_ready, // space free
  input wire logic [W-1:0] in_data, // write data
  output logic out_valid, // data present
  input wire logic out_ready, // read accept
  output logic [W-1:0] out_data, // head word
  output logic [AW:0] count // words held
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic wr, rd;
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign count = cnt_r;
  always_comb begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_nxt = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge clock) begin
    if (wr && !flush) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

// >>> logic/ssq_top.sv
// scan and motion command sequencer top
// assumes synchronous config port strobes and sensor trip levels already polarity-corrected
`timescale 1ns/100ps
`default_nettype none
module ssq_top
  import ssq_pkg::*;
#(
  parameter int HOLD_CYC = ssq_pkg::SSQ_HOLD_CYC
) (
  input wire logic clock, // 100mhz system clock (SSQ_CLK_MHZ)
  input wire logic rst_n, // async reset, active low
  input wire logic addr_wr, // config address write strobe
  input wire logic data_wr, // config data write strobe
  input wire logic data_rd, // config data read strobe
  input wire logic [7:0] wdata, // config write byte
  output logic [7:0] rdata, // config read byte
  output logic rvalid, // read byte valid pulse
  input wire logic sense1, // paper sensor one state
  input wire logic sense2, // paper sensor two state
  input wire logic sense1_en, // sensor one stop enable
  input wire logic sense2_en, // sensor two stop enable
  input wire logic [7:0] sense2_lines, // lines after sensor two trip
  input wire logic [7:0] sense2_steps, // full steps after sensor two trip
  input wire logic mode14, // 14-bit data mode
  input wire logic pixel_rate, // pixel-rate colour (c=3)
  input wire logic [1:0] bits_sel, // bits per pixel 1,2,4,8
  input wire logic [13:0] data_pixels, // data end minus data start
  input wire logic [3:0] horizontal_decimation_factor, // horizontal divider
  input wire logic pix_valid, // sensor sample valid
  input wire logic [7:0] pix_data, // sample byte in sensor order
  input wire logic fullstep, // one-cycle pulse per motor full step
  output logic pix_ready, // sample accepted
  output logic scanning, // scanning bit
  output logic motor_run, // stepper stepping
  output logic motor_dir, // 1 reverse
  output logic motor_power, // stepper hold power
  output logic [15:0] step_size, // active step size
  output logic mclk_en // divided master clock enable
);
  // ----------------------------------------
  // register port
  // ----------------------------------------
  logic [6:0] addr_r, addr_nxt;
  logic [7:0] cmd_r, cmd_nxt, div_r, div_nxt;
  logic [7:0] ffhi_r, ffhi_nxt, fflo_r, fflo_nxt, skhi_r, skhi_nxt, sklo_r, sklo_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt, cmd_wr;
  logic [SSQ_FIFO_AW:0] fcount;
  logic f_ovalid, f_oready, f_ivalid, f_iready, flush;
  logic [7:0] f_odata, f_idata;

  function automatic logic [7:0] fill_byte(input logic [SSQ_FIFO_AW:0] c);
    fill_byte = {3'h0, c};
  endfunction

  always_comb begin
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    div_nxt = div_r;
    ffhi_nxt = ffhi_r;
    fflo_nxt = fflo_r;
    skhi_nxt = skhi_r;
    sklo_nxt = sklo_r;
    cmd_wr = 1'b0;
    if (addr_wr) begin
      addr_nxt = wdata[6:0];
    end
    if (data_wr) begin
      case (addr_r)
        SSQ_REG_CMD: begin
          cmd_nxt = wdata;
          cmd_wr = 1'b1;
        end
        SSQ_REG_MCLK: div_nxt = {2'h0, wdata[5:0] & SSQ_MCLK_MASK};
        SSQ_REG_FFHI: ffhi_nxt = wdata;
        SSQ_REG_FFLO: fflo_nxt = wdata;
        SSQ_REG_SKHI: skhi_nxt = wdata;
        SSQ_REG_SKLO: sklo_nxt = wdata;
        default: ;
      endcase
    end
    rvalid_nxt = data_rd;
    f_oready = 1'b0;
    rdata_nxt = rdata_r;
    if (data_rd) begin
      case (addr_r)
        SSQ_REG_IMAGE: begin
          rdata_nxt = f_ovalid ? f_odata : SSQ_RST_BYTE;
          f_oready = f_ovalid;
        end
        SSQ_REG_FILL: rdata_nxt = fill_byte(fcount);
        SSQ_REG_CMD: rdata_nxt = cmd_r;
        SSQ_REG_MCLK: rdata_nxt = div_r;
        SSQ_REG_FFHI: rdata_nxt = ffhi_r;
        SSQ_REG_FFLO: rdata_nxt = fflo_r;
        SSQ_REG_SKHI: rdata_nxt = skhi_r;
        SSQ_REG_SKLO: rdata_nxt = sklo_r;
        default: rdata_nxt = SSQ_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= '0;
      cmd_r <= SSQ_RST_BYTE;
      div_r <= SSQ_RST_BYTE;
      ffhi_r <= SSQ_RST_BYTE;
      fflo_r <= SSQ_RST_BYTE;
      skhi_r <= SSQ_RST_BYTE;
      sklo_r <= SSQ_RST_BYTE;
      rdata_r <= SSQ_RST_BYTE;
      rvalid_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      div_r <= div_nxt;
      ffhi_r <= ffhi_nxt;
      fflo_r <= fflo_nxt;
      skhi_r <= skhi_nxt;
      sklo_r <= sklo_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;

  // ----------------------------------------
  // master clock divider
  // ----------------------------------------
  // ratio = 1 + code/2: count in whole clocks, odd codes alternate period lengths
  logic [6:0] mdiv_cnt_r, mdiv_cnt_nxt;
  logic mclk_r, mclk_nxt, half_r, half_nxt;
  logic [6:0] mper;
  always_comb begin
    // period in clocks alternates floor/ceil of (2+code)/2
    mper = 7'({1'b0, div_r[5:0]} + 7'd2) >> 1;
    if (div_r[0] && half_r) begin
      mper = mper + 7'd1;
    end
    mclk_nxt = 1'b0;
    half_nxt = half_r;
    mdiv_cnt_nxt = mdiv_cnt_r + 7'd1;
    if (mdiv_cnt_r + 7'd1 >= mper) begin
      mdiv_cnt_nxt = '0;
      mclk_nxt = 1'b1;
      half_nxt = !half_r;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mdiv_cnt_r <= '0;
      mclk_r <= 1'b0;
      half_r <= 1'b0;
    end else begin
      mdiv_cnt_r <= mdiv_cnt_nxt;
      mclk_r <= mclk_nxt;
      half_r <= half_nxt;
    end
  end
  // register port, fifo and motor step pulses stay on the undivided clock
  assign mclk_en = mclk_r;

  // ----------------------------------------
  // line byte count
  // ----------------------------------------
  function automatic logic [17:0] line_bytes(input logic m14, input logic prc,
                                             input logic [1:0] bs, input logic [13:0] px,
                                             input logic [3:0] hd);
    logic [13:0] q;
    logic [17:0] cq;
    q = (hd == 4'h0) ? px : px / hd;
    cq = prc ? 18'(q) * 18'd3 : 18'(q);
    if (m14) begin
      line_bytes = 18'(cq << 1);
    end else begin
      line_bytes = 18'(((cq << bs) >> 4) << 1);
    end
  endfunction

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  ssq_state_t st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [17:0] lb_r, lb_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic s1_r, s2_r, dir_r, dir_nxt, prog_r, prog_nxt, tailscan_r, tailscan_nxt;
  logic [7:0] tail_lines_r, tail_lines_nxt;
  logic [26:0] hold_r, hold_nxt;
  logic pwr_r, pwr_nxt, run_r, run_nxt, scan_r, scan_nxt;
  logic trip1, trip2, stop_new, starving, line_done;
  logic [2:0] cmd_f;
  assign cmd_f = cmd_nxt[SSQ_CMD_HI:SSQ_CMD_LO];
  assign trip1 = sense1_en && sense1 && !s1_r;
  assign trip2 = sense2_en && sense2 && !s2_r;
  assign stop_new = cmd_wr;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    lb_nxt = lb_r;
    stat_nxt = stat_r;
    dir_nxt = dir_r;
    prog_nxt = prog_r;
    tailscan_nxt = tailscan_r;
    tail_lines_nxt = tail_lines_r;
    scan_nxt = scan_r;
    flush = 1'b0;
    f_ivalid = 1'b0;
    f_idata = pix_data;
    pix_ready = 1'b0;
    line_done = 1'b0;
    starving = !f_iready;
    case (st_r)
      SSQ_ST_IDLE: begin
        if (cmd_wr) begin
          dir_nxt = (cmd_f == SSQ_CMD_REV) || (cmd_f == SSQ_CMD_PREV);
          prog_nxt = (cmd_f == SSQ_CMD_PFWD) || (cmd_f == SSQ_CMD_PREV);
          cnt_nxt = {skhi_r, sklo_r};
          case (cmd_f)
            SSQ_CMD_SCAN: begin
              st_nxt = SSQ_ST_SKIP;
              scan_nxt = 1'b1;
              flush = 1'b1;
            end
            SSQ_CMD_FWD, SSQ_CMD_PFWD: st_nxt = SSQ_ST_FEED;
            SSQ_CMD_REV, SSQ_CMD_PREV: st_nxt = SSQ_ST_FEED;
            default: ;
          endcase
        end
      end
      SSQ_ST_SKIP: begin
        if (stop_new || trip1) begin
          st_nxt = SSQ_ST_IDLE;
          scan_nxt = 1'b0;
        end else if (cnt_r == 16'h0000) begin
          st_nxt = SSQ_ST_SCAN;
          lb_nxt = line_bytes(mode14, pixel_rate, bits_sel, data_pixels,
                              horizontal_decimation_factor);
          stat_nxt = 2'd0;
        end else if (fullstep) begin
          cnt_nxt = cnt_r - 16'd1;
        end
      end
      SSQ_ST_SCAN: begin
        // samples pass in arrival order; colour plane order is the sensor's
        if (lb_r != 18'd0) begin
          f_ivalid = pix_valid;
          pix_ready = f_iready;
          if (pix_valid && f_iready) begin
            lb_nxt = lb_r - 18'd1;
          end
        end else begin
          f_ivalid = 1'b1;
          f_idata = (stat_r == 2'd0) ? fill_byte(fcount) : SSQ_RST_BYTE;
          if (f_iready) begin
            stat_nxt = stat_r + 2'd1;
            if (stat_r == 2'd1) begin
              line_done = 1'b1;
              stat_nxt = 2'd0;
              lb_nxt = line_bytes(mode14, pixel_rate, bits_sel, data_pixels,
                                  horizontal_decimation_factor);
            end
          end
        end
        if (tailscan_r && line_done) begin
          tail_lines_nxt = tail_lines_r - 8'd1;
          if (tail_lines_r <= 8'd1) begin
            st_nxt = SSQ_ST_IDLE;
            scan_nxt = 1'b0;
            tailscan_nxt = 1'b0;
          end
        end
        if (stop_new || trip1) begin
          st_nxt = SSQ_ST_IDLE;
          scan_nxt = 1'b0;
          tailscan_nxt = 1'b0;
        end else if (trip2 && !tailscan_r) begin
          if (sense2_lines == 8'h00) begin
            st_nxt = SSQ_ST_IDLE;
            scan_nxt = 1'b0;
          end else begin
            tailscan_nxt = 1'b1;
            tail_lines_nxt = sense2_lines;
          end
        end
      end
      SSQ_ST_FEED: begin
        if (stop_new || trip1) begin
          st_nxt = SSQ_ST_IDLE;
        end else if (trip2) begin
          if (!dir_r && sense2_steps != 8'h00) begin
            st_nxt = SSQ_ST_TAIL;
            cnt_nxt = {8'h00, sense2_steps};
          end else begin
            st_nxt = SSQ_ST_IDLE;
          end
        end else if (prog_r && cnt_r == 16'h0000) begin
          st_nxt = SSQ_ST_IDLE;
        end else if (prog_r && fullstep) begin
          cnt_nxt = cnt_r - 16'd1;
        end
      end
      SSQ_ST_TAIL: begin
        if (stop_new || cnt_r == 16'h0000) begin
          st_nxt = SSQ_ST_IDLE;
        end else if (fullstep) begin
          cnt_nxt = cnt_r - 16'd1;
        end
      end
      default: st_nxt = SSQ_ST_IDLE;
    endcase
    // full buffer: stop stepping; hold power until the timeout runs out
    run_nxt = (st_nxt == SSQ_ST_SKIP) || (st_nxt == SSQ_ST_FEED) || (st_nxt == SSQ_ST_TAIL) ||
              ((st_nxt == SSQ_ST_SCAN) && !starving);
    hold_nxt = hold_r;
    pwr_nxt = pwr_r;
    if (run_nxt) begin
      hold_nxt = '0;
      pwr_nxt = 1'b1;
    end else if (pwr_r) begin
      if (hold_r >= 27'(HOLD_CYC - 1)) begin
        pwr_nxt = 1'b0;
      end else begin
        hold_nxt = hold_r + 27'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SSQ_ST_IDLE;
      cnt_r <= '0;
      lb_r <= '0;
      stat_r <= '0;
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      dir_r <= 1'b0;
      prog_r <= 1'b0;
      tailscan_r <= 1'b0;
      tail_lines_r <= '0;
      hold_r <= '0;
      pwr_r <= 1'b0;
      run_r <= 1'b0;
      scan_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      lb_r <= lb_nxt;
      stat_r <= stat_nxt;
      s1_r <= sense1;
      s2_r <= sense2;
      dir_r <= dir_nxt;
      prog_r <= prog_nxt;
      tailscan_r <= tailscan_nxt;
      tail_lines_r <= tail_lines_nxt;
      hold_r <= hold_nxt;
      pwr_r <= pwr_nxt;
      run_r <= run_nxt;
      scan_r <= scan_nxt;
    end
  end

  // ----------------------------------------
  // outputs and line buffer
  // ----------------------------------------
  logic [15:0] ss_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ss_r <= '0;
    end else begin
      ss_r <= {ffhi_r, fflo_r};
    end
  end
  assign step_size = ss_r;
  assign scanning = scan_r;
  assign motor_run = run_r;
  assign motor_dir = dir_r;
  assign motor_power = pwr_r;

  ssq_fifo #(
    .W(SSQ_FIFO_W),
    .D(SSQ_FIFO_D),
    .AW(SSQ_FIFO_AW)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(f_ivalid),
    .in_ready(f_iready),
    .in_data(f_idata),
    .out_valid(f_ovalid),
    .out_ready(f_oready),
    .out_data(f_odata),
    .count(fcount)
  );
endmodule
`default_nettype wire

// >>> tb/ssq_top_properties.sv
// port-level timing properties of the sequencer top
// assumes a bind onto ssq_top, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module ssq_top_properties
  import ssq_pkg::*;
#(
  parameter int HOLD_CYC = 50
) (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic addr_wr, // address strobe
  input wire logic data_wr, // write strobe
  input wire logic data_rd, // read strobe
  input wire logic [7:0] wdata, // write byte
  input wire logic [7:0] rdata, // read byte
  input wire logic rvalid, // read valid
  input wire logic sense1, // sensor one
  input wire logic sense2, // sensor two
  input wire logic sense1_en, // sensor one enable
  input wire logic sense2_en, // sensor two enable
  input wire logic [7:0] sense2_steps, // tail steps
  input wire logic scanning, // scanning bit
  input wire logic motor_run, // stepping
  input wire logic motor_dir, // reverse
  input wire logic motor_power, // hold power
  input wire logic mclk_en // master enable
);
  logic [6:0] addr_r;
  logic [5:0] div_r;
  logic [3:0] age_r;
  logic [31:0] hold_r;
  logic cmd_wr;
  assign cmd_wr = data_wr && (addr_r == SSQ_REG_CMD);
  // ----------------------------------------
  // shadow of address, divider code and hold time
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_r <= 7'h00;
      div_r <= 6'h00;
      age_r <= 4'h0;
      hold_r <= 32'h0;
    end else begin
      if (addr_wr) addr_r <= wdata[6:0];
      if (data_wr && addr_r == SSQ_REG_MCLK) div_r <= wdata[5:0];
      age_r <= (data_wr && addr_r == SSQ_REG_MCLK) ? 4'h0 : (age_r == 4'hf ? age_r : age_r + 4'h1);
      hold_r <= (motor_power && !motor_run) ? hold_r + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_read_answer; data_rd |=> rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_read_cause; rvalid |-> $past(data_rd); endproperty
  a_read_cause: assert property (p_read_cause) else $error("spurious read valid");
  property p_rdata_hold; !$past(data_rd) |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved");
  property p_scan_start;
    cmd_wr && wdata[2:0] == SSQ_CMD_SCAN && !scanning && !motor_run |=> scanning;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("scan did not start");
  property p_cmd_idle; cmd_wr && wdata[2:0] == SSQ_CMD_IDLE |-> ##[1:2] (!scanning && !motor_run); endproperty
  a_cmd_idle: assert property (p_cmd_idle) else $error("idle did not stop");
  property p_s1_trip; sense1_en && $rose(sense1) && scanning |-> ##[1:3] !scanning; endproperty
  a_s1_trip: assert property (p_s1_trip) else $error("sensor one did not stop scan");
  property p_rev_no_tail; sense2_en && $rose(sense2) && motor_run && motor_dir |-> ##[1:3] !motor_run; endproperty
  a_rev_no_tail: assert property (p_rev_no_tail) else $error("reverse kept moving");
  property p_fwd_tail;
    sense2_en && $rose(sense2) && motor_run && !motor_dir && !scanning && sense2_steps != 8'h00
      |-> ##1 motor_run [*2];
  endproperty
  a_fwd_tail: assert property (p_fwd_tail) else $error("forward tail missing");
  property p_mclk_div1; age_r == 4'hf && div_r == 6'h00 |-> mclk_en; endproperty
  a_mclk_div1: assert property (p_mclk_div1) else $error("divide by one broken");
  property p_mclk_div2; age_r == 4'hf && div_r == 6'h02 && mclk_en |=> !mclk_en ##1 mclk_en; endproperty
  a_mclk_div2: assert property (p_mclk_div2) else $error("divide by two broken");
  property p_hold; motor_power && !motor_run |-> hold_r <= HOLD_CYC + 2; endproperty
  a_hold: assert property (p_hold) else $error("hold power not removed");
  c_scan: cover property (scanning ##1 !scanning);
  c_rev: cover property (motor_run && motor_dir);
  c_div2: cover property (age_r == 4'hf && div_r == 6'h02);
endmodule
bind ssq_top ssq_top_properties #(.HOLD_CYC(HOLD_CYC)) u_ssq_top_properties (.clock, .rst_n, .addr_wr,
  .data_wr, .data_rd, .wdata, .rdata, .rvalid, .sense1, .sense2, .sense1_en, .sense2_en, .sense2_steps,
  .scanning, .motor_run, .motor_dir, .motor_power, .mclk_en);
`default_nettype wire

// >>> tb/ssq_host_model.sv
// host side model: drives the config address/data port
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module ssq_host_model (
  input wire logic clock, // clock
  output logic addr_wr, // address strobe
  output logic data_wr, // write strobe
  output logic data_rd, // read strobe
  output logic [7:0] wdata, // write byte
  input wire logic [7:0] rdata, // read byte
  input wire logic rvalid // read valid
);
  logic [7:0] cur_a;
  initial begin
    addr_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    wdata = 8'h00;
    cur_a = 8'hff;
  end
  // address written once, then any number of data accesses
  task automatic sel(input logic [6:0] a);
    if (cur_a !== {1'b0, a}) begin
      @(posedge clock); #1;
      addr_wr = 1'b1;
      wdata = {1'b0, a};
      @(posedge clock); #1;
      addr_wr = 1'b0;
      wdata = ~wdata;
      cur_a = {1'b0, a};
    end
  endtask
  // a zero to the command register is how the host aborts
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sel(a);
    @(posedge clock); #1;
    data_wr = 1'b1;
    wdata = d;
    @(posedge clock); #1;
    data_wr = 1'b0;
    wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    sel(a);
    @(posedge clock); #1;
    data_rd = 1'b1;
    @(posedge clock); #1;
    data_rd = 1'b0;
    ok = (rvalid === 1'b1);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// >>> tb/ssq_top_tb.sv
// self-checking bench for the sequencer top
// assumes the host model drives the config port and the bench drives sensors and samples
`timescale 1ns/100ps
`default_nettype none
module ssq_top_tb;
  import ssq_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, addr_wr, data_wr, data_rd, rvalid, sense1 = 0, sense2 = 0;
  logic sense1_en = 0, sense2_en = 0, mode14 = 0, pixel_rate = 0, pix_valid = 0, fullstep = 0;
  logic pix_ready, scanning, motor_run, motor_dir, motor_power, mclk_en;
  logic [7:0] wdata, rdata, sense2_steps = 8'h00, pix_data = 8'h00;
  logic [1:0] bits_sel = 2'h3;
  logic [13:0] data_pixels = 14'h0004;
  logic [3:0] hdf = 4'h1;
  logic [15:0] step_size;
  int mismatches = 0, n_tests = 0;
  ssq_top #(.HOLD_CYC(50)) u_ssq_top (.clock, .rst_n, .addr_wr, .data_wr, .data_rd, .wdata, .rdata, .rvalid,
    .sense1, .sense2, .sense1_en, .sense2_en, .sense2_lines(8'h01), .sense2_steps, .mode14, .pixel_rate,
    .bits_sel, .data_pixels, .horizontal_decimation_factor(hdf), .pix_valid, .pix_data, .fullstep,
    .pix_ready, .scanning, .motor_run, .motor_dir, .motor_power, .step_size, .mclk_en);
  ssq_host_model u_ssq_host_model (.clock, .addr_wr, .data_wr, .data_rd, .wdata, .rdata, .rvalid);
  always #5 clock = ~clock;
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] d;
    logic ok;
    u_ssq_host_model.rd(a, d, ok);
    chk({nm, " answered"}, {15'h0, ok}, 16'h1);
    chk(nm, {8'h00, d}, {8'h00, exp});
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? motor_run : (s == 1 ? scanning : pix_ready);
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(s) !== v && k < lim) begin
      @(posedge clock); #1;
      k++;
    end
    chk("wait", {15'h0, pick(s)}, {15'h0, v});
    if (pick(s) !== v) end_sim();
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clock); #1;
      fullstep = 1'b1;
      @(posedge clock); #1;
      fullstep = 1'b0;
    end
  endtask
  task automatic feed(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      pix_valid = 1'b1;
      pix_data = base + 8'(i);
      wait_for(2, 1'b1, 60);
      @(posedge clock); #1;
    end
    pix_valid = 1'b0;
    pix_data = ~pix_data;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    chk("idle outputs", {13'h0, scanning, motor_run, motor_power}, 16'h0);
    u_ssq_host_model.wr(SSQ_REG_FFHI, 8'h12);
    u_ssq_host_model.wr(SSQ_REG_FFLO, 8'h34);
    u_ssq_host_model.wr(7'h30, 8'h5a);
    u_ssq_host_model.wr(SSQ_REG_MCLK, 8'h02);
    rdchk(SSQ_REG_FFHI, 8'h12, "step hi");
    rdchk(7'h30, 8'h00, "unmapped");
    rdchk(SSQ_REG_MCLK, 8'h02, "divider");
    rdchk(SSQ_REG_IMAGE, 8'h00, "empty port");
    rdchk(SSQ_REG_FILL, 8'h00, "empty fill");
  endtask
  task automatic t_feed(input logic [2:0] code, input int extra);
    u_ssq_host_model.wr(SSQ_REG_CMD, {5'h0, code});
    wait_for(0, 1'b1, 20);
    chk("direction", {15'h0, motor_dir}, {15'h0, code[1]});
    chk("fast step", step_size, 16'h1234);
    if (extra > 0) begin
      step(extra - 1);
      chk("still running", {15'h0, motor_run}, 16'h1);
      step(1);
      wait_for(0, 1'b0, 10);
    end
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h00);
    wait_for(0, 1'b0, 10);
  endtask
  task automatic t_tail();
    sense2_en = 1'b1;
    sense2_steps = 8'h02;
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h01);
    wait_for(0, 1'b1, 20);
    sense2 = 1'b1;
    step(1);
    chk("tail step", {15'h0, motor_run}, 16'h1);
    step(1);
    wait_for(0, 1'b0, 10);
    sense2 = 1'b0;
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h00);
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h02);
    wait_for(0, 1'b1, 20);
    sense2 = 1'b1;
    wait_for(0, 1'b0, 4);
    sense2 = 1'b0;
    sense2_en = 1'b0;
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h00);
  endtask
  task automatic t_line(input int nb, input logic by_sensor);
    u_ssq_host_model.wr(SSQ_REG_CMD, {5'h0, SSQ_CMD_SCAN});
    chk("scanning", {15'h0, scanning}, 16'h1);
    pix_valid = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk("skip holds data", {15'h0, pix_ready}, 16'h0);
    step(2);
    feed(nb, 8'ha0);
    if (by_sensor) begin
      sense1_en = 1'b1;
      sense1 = 1'b1;
      wait_for(1, 1'b0, 5);
      sense1 = 1'b0;
    end else begin
      sense2_en = 1'b1;
      sense2 = 1'b1;
      wait_for(1, 1'b0, 5);
      sense2 = 1'b0;
    end
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h00);
    for (int i = 0; i < nb; i++) rdchk(SSQ_REG_IMAGE, 8'ha0 + 8'(i), "line byte");
    rdchk(SSQ_REG_IMAGE, 8'(nb), "status low");
    rdchk(SSQ_REG_IMAGE, 8'h00, "status high");
  endtask
  task automatic t_full();
    data_pixels = 14'h0020;
    u_ssq_host_model.wr(SSQ_REG_CMD, {5'h0, SSQ_CMD_SCAN});
    step(2);
    feed(16, 8'h40);
    #1 pix_valid = 1'b1;
    repeat (60) @(posedge clock);
    #1;
    chk("full refuses", {15'h0, pix_ready}, 16'h0);
    chk("power off", {14'h0, motor_run, motor_power}, 16'h0);
    pix_valid = 1'b0;
    rdchk(SSQ_REG_FILL, 8'h10, "fill level");
    u_ssq_host_model.wr(SSQ_REG_CMD, 8'h00);
    for (int i = 0; i < 16; i++) rdchk(SSQ_REG_IMAGE, 8'h40 + 8'(i), "drain");
    rdchk(SSQ_REG_IMAGE, 8'h00, "drained");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    t_regs();
    t_feed(SSQ_CMD_FWD, 0);
    t_feed(SSQ_CMD_REV, 0);
    u_ssq_host_model.wr(SSQ_REG_SKLO, 8'h03);
    t_feed(SSQ_CMD_PFWD, 3);
    t_feed(SSQ_CMD_PREV, 3);
    t_tail();
    u_ssq_host_model.wr(SSQ_REG_SKLO, 8'h02);
    t_line(4, 1'b1);
    mode14 = 1'b1;
    pixel_rate = 1'b1;
    data_pixels = 14'h0002;
    t_line(12, 1'b0);
    mode14 = 1'b0;
    pixel_rate = 1'b0;
    t_full();
    end_sim();
  end
  initial begin
    #900000;
    mismatches++;
    $display("MISMATCH run expected finish seen timeout");
    end_sim();
  end
endmodule
`default_nettype wire
